// file: cavr_ca_reference_register.sv
/*
  Command/address reference-level mode register with two set-point copies.
  Assumes commands are synchronous one-cycle strobes and that both set-point selects come from
  the set-point control register elsewhere in the device.
  Also assumes the host writes only valid level codes; a reserved code is stored and only flagged,
  and the analog side treats the fraction output as meaningless while that flag stands.
*/
`timescale 1ns/1ps
`include "cavr_cfg.svh"

module cavr_ca_reference_register
  import cavr_pkg::*;
#(
  parameter int DQ_WIDTH = 16
) (
  input  wire logic                clock_i,
  input  wire logic                rst_n_i,
  input  wire cavr_cmd_t           cmd_i,
  input  wire logic                setpoint_access_select_i,
  input  wire logic                setpoint_operate_select_i,
  output logic [DQ_WIDTH-1:0]      rd_data_o,
  output logic                     rd_valid_o,
  output logic                     ca_reference_range_select_o,
  output logic [5:0]               ca_reference_level_code_o,
  output logic [15:0]              ca_reference_mpct_o,
  output logic                     level_code_reserved_o
);

  // ----------------------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------------------
  // The read answer needs at least the eight register lanes.
  if (DQ_WIDTH < 8) begin : g_bad_width
    $error("DQ_WIDTH must be at least 8.");
  end

  // ----------------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------------
  // True when a command targets this register address.
  function automatic logic hits_reg(input cavr_cmd_t c);
    return c.addr == `CAVR_CA_REFERENCE_LEVEL_ADDR;
  endfunction

  logic wr_hit;
  logic rd_hit;

  // Write and read strobes aimed at this register.
  assign wr_hit = cmd_i.wr && hits_reg(cmd_i);
  assign rd_hit = cmd_i.rd && hits_reg(cmd_i);

  // ----------------------------------------------------------------------------
  // Set-point storage
  // ----------------------------------------------------------------------------
  cavr_ref_t sp_reg  [2];
  cavr_ref_t sp_next [2];

  // Each copy updates only when the access select names it; otherwise it holds.
  for (genvar g = 0; g < 2; g++) begin : g_sp
    always_comb begin
      sp_next[g] = sp_reg[g];
      if (wr_hit && (setpoint_access_select_i == 1'(g))) begin
        sp_next[g].range_sel  = cmd_i.op[`CAVR_RANGE_BIT];
        sp_next[g].level_code = cmd_i.op[`CAVR_LEVEL_MSB:`CAVR_LEVEL_LSB];
      end
    end

    // Both copies come out of reset in the upper range at the default level.
    always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
        sp_reg[g].range_sel  <= `CAVR_RANGE_RESET;
        sp_reg[g].level_code <= `CAVR_LEVEL_RESET;
      end else begin
        sp_reg[g] <= sp_next[g];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------------
  cavr_rd_state_t    rd_state_reg;
  cavr_rd_state_t    rd_state_next;
  logic [DQ_WIDTH-1:0] rd_data_reg;
  logic [DQ_WIDTH-1:0] rd_data_next;
  cavr_ref_t         rd_src;

  // A read answers one cycle later from the copy named by the access select.
  always_comb begin
    rd_src        = sp_reg[setpoint_access_select_i];
    rd_state_next = rd_hit ? CAVR_RD_DRIVE : CAVR_RD_IDLE;
    rd_data_next  = '0;
    if (rd_hit) begin
      rd_data_next[`CAVR_RANGE_BIT] = rd_src.range_sel;
      rd_data_next[`CAVR_LEVEL_MSB:`CAVR_LEVEL_LSB] = rd_src.level_code;
    end
  end

  // Registers the read answer; the lanes return to zero when no answer stands.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rd_state_reg <= CAVR_RD_IDLE;
      rd_data_reg  <= '0;
    end else begin
      rd_state_reg <= rd_state_next;
      rd_data_reg  <= rd_data_next;
    end
  end

  assign rd_valid_o = (rd_state_reg == CAVR_RD_DRIVE);
  assign rd_data_o  = rd_data_reg;

  // ----------------------------------------------------------------------------
  // Operating outputs
  // ----------------------------------------------------------------------------
  cavr_ref_t   op_src;
  cavr_ref_t   op_reg;
  logic [15:0] mpct_reg;
  logic [15:0] mpct_next;
  logic        rsvd_reg;
  logic        rsvd_next;

  // Only the operating copy drives the reference; the level becomes a supply fraction.
  // Reserved codes of 37h and up in the upper range wrap the 16-bit fraction, which is
  // harmless because the reserved flag marks the value as unusable.
  always_comb begin
    op_src    = sp_reg[setpoint_operate_select_i];
    mpct_next = (op_src.range_sel ? `CAVR_BASE_HIGH_MPCT : `CAVR_BASE_LOW_MPCT)
              + 16'(op_src.level_code * `CAVR_STEP_MPCT);
    rsvd_next = (op_src.level_code > `CAVR_LEVEL_MAX);
  end

  // Registers the operating view so the analog side sees glitch-free codes.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      op_reg.range_sel  <= `CAVR_RANGE_RESET;
      op_reg.level_code <= `CAVR_LEVEL_RESET;
      mpct_reg          <= `CAVR_BASE_HIGH_MPCT + 16'(`CAVR_LEVEL_RESET * `CAVR_STEP_MPCT);
      rsvd_reg          <= 1'b0;
    end else begin
      op_reg   <= op_src;
      mpct_reg <= mpct_next;
      rsvd_reg <= rsvd_next;
    end
  end

  assign ca_reference_range_select_o = op_reg.range_sel;
  assign ca_reference_level_code_o   = op_reg.level_code;
  assign ca_reference_mpct_o         = mpct_reg;
  assign level_code_reserved_o       = rsvd_reg;

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // Commands to other addresses never start an answer.
  a_foreign_addr_quiet: assert property ((cmd_i.rd && !hits_reg(cmd_i)) |=> !rd_valid_o)
    else $error("Read answer for a foreign address.");

  // Reserved bit and upper lanes always read zero.
  a_read_upper_zero: assert property (rd_data_o[DQ_WIDTH-1:7] == '0)
    else $error("Reserved bit or unused lane not zero.");

  // A read answers with the access copy of the previous cycle.
  a_read_content: assert property (rd_hit |=> rd_valid_o &&
      rd_data_o[6:0] == {$past(rd_src.range_sel), $past(rd_src.level_code)})
    else $error("Read answer does not match the selected copy.");

  // A write followed by a read of the same copy returns the written value.
  a_write_read_back: assert property ((wr_hit && !cmd_i.rd) ##1
      (rd_hit && setpoint_access_select_i == $past(setpoint_access_select_i))
      |=> rd_data_o[6:0] == $past(cmd_i.op[6:0], 2))
    else $error("Read back differs from the last write.");

  // A write never disturbs the copy not named by the access select.
  a_other_copy_kept: assert property (wr_hit |=>
      sp_reg[!$past(setpoint_access_select_i)] == $past(sp_reg[!setpoint_access_select_i]))
    else $error("Write reached the unselected copy.");

  // Without a write both copies hold.
  a_value_retained: assert property (!wr_hit |=> $stable(sp_reg[0]) && $stable(sp_reg[1]))
    else $error("Stored value changed without a write.");

  // The operating outputs follow the operating copy one cycle later.
  a_operate_copy: assert property (1'b1 |=> {ca_reference_range_select_o,
      ca_reference_level_code_o} == $past({op_src.range_sel, op_src.level_code}))
    else $error("Operating outputs not from the operating copy.");

  // Code zero sits exactly at the base of the chosen range.
  a_range_base: assert property (ca_reference_level_code_o == 6'h00 |->
      ca_reference_mpct_o == (ca_reference_range_select_o ? `CAVR_BASE_HIGH_MPCT
                                                          : `CAVR_BASE_LOW_MPCT))
    else $error("Code zero not at the range base.");

  // Codes above the top valid code are flagged.
  a_reserved_flag: assert property (level_code_reserved_o ==
      (ca_reference_level_code_o > `CAVR_LEVEL_MAX))
    else $error("Reserved code flag wrong.");

  // With no answer standing, every data lane is low.
  a_idle_lanes_zero: assert property (!rd_valid_o |-> rd_data_o == '0)
    else $error("Data lanes not zero while idle.");

  // An answer appears only after a read of this register.
  a_answer_needs_read: assert property (rd_valid_o |-> $past(rd_hit))
    else $error("Answer without a read of this register.");

  // A write lands in the copy named by the access select, with the reserved bit dropped.
  a_write_lands: assert property (wr_hit |=>
      sp_reg[$past(setpoint_access_select_i)] == $past(cmd_i.op[6:0]))
    else $error("Write did not reach the selected copy.");

  // Main scenarios.
  c_write_sp1: cover property (wr_hit && setpoint_access_select_i);
  c_range_base: cover property (ca_reference_level_code_o == 6'h00);
  c_read_back: cover property (wr_hit ##1 rd_hit);
  c_switch_op: cover property (wr_hit && setpoint_access_select_i != setpoint_operate_select_i
                               ##[1:4] $changed(setpoint_operate_select_i));
  c_low_range: cover property (!ca_reference_range_select_o);

endmodule

// file: cavr_cfg.svh
/*
  Constants of the command/address reference-level mode register: offsets, field positions,
  reset values and the level-to-fraction scaling. Assumes inclusion by bare name only.
*/
`ifndef CAVR_CFG_SVH
`define CAVR_CFG_SVH

// ----------------------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------------------
`define CAVR_CA_REFERENCE_LEVEL_ADDR 6'h0c
`define CAVR_RSVD_BIT                7
`define CAVR_RANGE_BIT               6
`define CAVR_LEVEL_MSB               5
`define CAVR_LEVEL_LSB               0
`define CAVR_LEVEL_MAX               6'h32
`define CAVR_RANGE_RESET             1'b1
`define CAVR_LEVEL_RESET             6'h1d

// ----------------------------------------------------------------------------
// Level scaling, in thousandths of a percent of the I/O supply
// ----------------------------------------------------------------------------
`define CAVR_BASE_LOW_MPCT           16'h3a98
`define CAVR_BASE_HIGH_MPCT          16'h8084
`define CAVR_STEP_MPCT               16'h0257

`endif

// file: cavr_host_model.sv
/*
  Host controller model that issues mode register commands and drives both set-point selects.
  Assumes the bench calls its tasks and that the device samples on the rising clock edge.
*/
`timescale 1ns/1ps

module cavr_host_model
  import cavr_pkg::*;
(
  input  wire logic clock_i,
  output cavr_cmd_t cmd_o,
  output logic      access_sel_o,
  output logic      operate_sel_o
);
  // ----------------------------------------------------------------
  // Command and select drivers
  // ----------------------------------------------------------------
  // Idle bus at time zero, with junk on the address and data fields.
  initial begin
    cmd_o = 15'h0a5a;
    access_sel_o = 1'b0;
    operate_sel_o = 1'b0;
  end

  // One strobe cycle; the op field carries range and level together.
  task automatic issue(input logic wr, input logic rd, input logic [5:0] addr,
                       input logic [7:0] op);
    @(posedge clock_i);
    #1;
    cmd_o = {wr, rd, addr, op};
    @(posedge clock_i);
    #1;
    cmd_o = {2'b00, ~addr, ~op}; // Released fields show the inverse, never a stale value.
  endtask

  // A write and then a read in the very next cycle, with no idle cycle between.
  task automatic wr_rd(input logic [5:0] addr, input logic [7:0] op);
    @(posedge clock_i);
    #1;
    cmd_o = {2'b10, addr, op};
    @(posedge clock_i);
    #1;
    cmd_o = {2'b01, addr, ~op};
    @(posedge clock_i);
    #1;
    cmd_o = {2'b00, ~addr, ~op};
  endtask

  // Select changes are made 1 ns after an edge, access and operate selects in the same step.
  task automatic set_sel(input logic acc, input logic opr);
    @(posedge clock_i);
    #1;
    access_sel_o = acc;
    operate_sel_o = opr;
  endtask
endmodule

// file: cavr_pkg.sv
/*
  Types shared by the reference-level mode register: the command bundle and one set-point copy.
  Assumes the command fields arrive already decoded from the command bus.
*/
package cavr_pkg;

  // One decoded mode register command for a single clock cycle.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] op;
  } cavr_cmd_t;

  // One set-point copy of the register.
  typedef struct packed {
    logic       range_sel;
    logic [5:0] level_code;
  } cavr_ref_t;

  // Read path sequencing.
  typedef enum logic [0:0] {
    CAVR_RD_IDLE = 1'b0,
    CAVR_RD_DRIVE = 1'b1
  } cavr_rd_state_t;

endpackage

// file: tb_ca_vref_mode_register.sv
/*
  Self-checking bench for the reference-level mode register.
  Assumes the host model drives every command and select input of the design.
*/
`timescale 1ns/1ps

module tb_ca_vref_mode_register
  import cavr_pkg::*;
;
  // ----------------------------------------------------------------
  // Clock, reset, wiring
  // ----------------------------------------------------------------
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  cavr_cmd_t   cmd;
  logic        acc_sel;
  logic        opr_sel;
  logic        rd_valid;
  logic        rng;
  logic        rsv;
  logic [15:0] rd_data;
  logic [15:0] mpct;
  logic [5:0]  lvl;
  int          n_fail = 0;
  int          n_checks = 0;

  // Clock of 100 ns period.
  always #50 clock_i = ~clock_i;

  cavr_host_model host (.clock_i(clock_i), .cmd_o(cmd), .access_sel_o(acc_sel),
                        .operate_sel_o(opr_sel));

  cavr_ca_reference_register #(.DQ_WIDTH(16)) dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .cmd_i(cmd),
    .setpoint_access_select_i(acc_sel), .setpoint_operate_select_i(opr_sel),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .ca_reference_range_select_o(rng),
    .ca_reference_level_code_o(lvl), .ca_reference_mpct_o(mpct),
    .level_code_reserved_o(rsv));

  // ----------------------------------------------------------------
  // Compare tasks and verdict
  // ----------------------------------------------------------------
  // Counts one comparison and reports a mismatch at once.
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Reads the selected copy; the answer stands one cycle after the command.
  task automatic chk_rd(input logic [15:0] exp);
    host.issue(1'b0, 1'b1, 6'h0c, 8'h00);
    cmp("rd_valid", 16'h0001, {15'h0000, rd_valid});
    cmp("rd_data", exp, rd_data);
  endtask

  // Checks the operating outputs once a write or select change has settled.
  task automatic chk_op(input logic r, input logic [5:0] l);
    repeat (2) @(posedge clock_i);
    #1;
    cmp("range", {15'h0000, r}, {15'h0000, rng});
    cmp("level", {10'h000, l}, {10'h000, lvl});
    cmp("mpct", (r ? 16'h8084 : 16'h3a98) + {10'h000, l} * 16'h0257, mpct);
    cmp("reserved", {15'h0000, l > 6'h32}, {15'h0000, rsv});
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence and watchdog
  // ----------------------------------------------------------------
  // Main sequence: reset, both copies, selects, refusals, mid-run reset.
  initial begin
    repeat (6) @(posedge clock_i);
    #1;
    rst_n_i = 1'b1;
    chk_op(1'b1, 6'h1d);
    chk_rd(16'h005d);
    host.set_sel(1'b1, 1'b0);
    chk_rd(16'h005d);
    host.issue(1'b1, 1'b0, 6'h0c, 8'hc5);
    chk_rd(16'h0045);
    chk_op(1'b1, 6'h1d);
    host.issue(1'b1, 1'b1, 6'h0d, 8'h00);
    cmp("rd_valid", 16'h0000, {15'h0000, rd_valid});
    chk_rd(16'h0045);
    host.set_sel(1'b1, 1'b1);
    chk_op(1'b1, 6'h05);
    host.set_sel(1'b0, 1'b1);
    host.issue(1'b1, 1'b0, 6'h0c, 8'h32);
    chk_op(1'b1, 6'h05);
    host.set_sel(1'b0, 1'b0);
    chk_op(1'b0, 6'h32);
    host.issue(1'b1, 1'b1, 6'h0c, 8'h33);
    cmp("rd_data", 16'h0032, rd_data);
    chk_op(1'b0, 6'h33);
    chk_rd(16'h0033);
    host.wr_rd(6'h0c, 8'h40);
    cmp("rd_valid", 16'h0001, {15'h0000, rd_valid});
    cmp("rd_data", 16'h0040, rd_data);
    chk_op(1'b1, 6'h00);
    host.issue(1'b1, 1'b0, 6'h0c, 8'h80);
    chk_rd(16'h0000);
    chk_op(1'b0, 6'h00);
    rst_n_i = 1'b0;
    @(posedge clock_i);
    #1;
    rst_n_i = 1'b1;
    chk_rd(16'h005d);
    chk_op(1'b1, 6'h1d);
    host.set_sel(1'b1, 1'b1);
    chk_rd(16'h005d);
    end_of_test();
  end

  // Cuts a hang short well after the roughly 60 cycles the tests take.
  initial begin
    #(400 * 100);
    n_fail++;
    end_of_test();
  end
endmodule
